// ==== svr_host_model.sv ====
`timescale 1ns/10ps
module svr_host_model (
	output logic scl_o,
	output logic sda_o
);
	// long half bit keeps each level past the sample filter
	localparam int HALF = 48;
	initial begin
		scl_o = 1'h1;
		sda_o = 1'h1;
	end
	// ack slots left released, the pull-up gives high
	task automatic send(input logic c, input logic n,
		input logic [7:0] v, input logic p0, input logic p1);
		logic [26:0] f;
		f = {5'h18, c, n, 2'h1, p0, v[7:1], 1'h1, v[0], p1, 7'h01};
		sda_o = 1'h0;
		#HALF scl_o = 1'h0;
		for (int i = 26; i >= 0; i--) begin
			#HALF sda_o = f[i];
			#HALF scl_o = 1'h1;
			#HALF scl_o = 1'h0;
		end
		#HALF sda_o = 1'h0;
		#HALF scl_o = 1'h1;
		#HALF sda_o = 1'h1;
		#HALF;
	endtask : send
endmodule : svr_host_model

// ==== svr_link_rx.sv ====
`timescale 1ns/10ps
module svr_link_rx
	import svr_pkg::*;
(
	input  wire logic       link_clk_i,
	input  wire logic       nrst_i,
	input  wire logic       power_ok_input_i,
	input  wire logic       vid_link_clock_i,
	input  wire logic       vid_link_data_i,
	output logic            vid_link_data_o,
	output logic            vid_link_data_oe_n_o,
	output logic            frame_tgl_o,
	output logic            frame_sel_core_o,
	output logic            frame_sel_nb_o,
	output logic [7:0]      frame_code_o,
	output logic            frame_psi0_n_o,
	output logic            frame_psi1_n_o
);
	import svr_pkg::*;

	// bit 2 power ok, bit 1 link clock, bit 0 link data
	logic [2:0]  sync1_q;
	logic [2:0]  sync2_q;
	logic [2:0]  sync3_q;
	logic [2:0]  filt_q;
	logic [2:0]  filt_d;
	logic        active_q;
	logic        active_d;
	logic [4:0]  cnt_q;
	logic [4:0]  cnt_d;
	logic [26:0] bits_q;
	logic [26:0] bits_d;
	logic        tgl_q;
	logic        tgl_d;
	logic        core_q;
	logic        core_d;
	logic        nb_q;
	logic        nb_d;
	logic [7:0]  code_q;
	logic [7:0]  code_d;
	logic        psi0_q;
	logic        psi0_d;
	logic        psi1_q;
	logic        psi1_d;
	logic        start_w;
	logic        stop_w;
	logic        rise_w;

	always_comb begin
		// a change counts once stages two and three agree
		filt_d = (sync2_q & ~(sync2_q ^ sync3_q))
			| (filt_q & (sync2_q ^ sync3_q));
		start_w = filt_q[1] & filt_d[1] & filt_q[0] & ~filt_d[0];
		stop_w  = filt_q[1] & filt_d[1] & ~filt_q[0] & filt_d[0];
		rise_w  = ~filt_q[1] & filt_d[1];
		active_d = active_q;
		cnt_d    = cnt_q;
		bits_d   = bits_q;
		tgl_d    = tgl_q;
		core_d   = core_q;
		nb_d     = nb_q;
		code_d   = code_q;
		psi0_d   = psi0_q;
		psi1_d   = psi1_q;
		if (!filt_d[2]) begin
			active_d = 1'b0;
			cnt_d    = '0;
		end else if (start_w) begin
			active_d = 1'b1;
			cnt_d    = '0;
		end else if (stop_w) begin
			active_d = 1'b0;
			// hand over only a whole, well formed frame after stop
			if (active_q && cnt_q == FRAME_RISES
				&& bits_q[TAG_HI:TAG_LO] == ADDR_TAG
				&& !bits_q[ZERO_BIT]) begin
				tgl_d  = ~tgl_q;
				core_d = bits_q[SEL_CORE];
				nb_d   = bits_q[SEL_NB];
				code_d = {bits_q[CODE_HI:CODE_MID], bits_q[CODE_LSB]};
				psi0_d = bits_q[PSI0_BIT];
				psi1_d = bits_q[PSI1_BIT];
			end
		end else if (active_q && rise_w) begin
			// the stop's own clock rise is counted but shifts nothing
			if (cnt_q < FRAME_BITS) begin
				bits_d = {bits_q[25:0], filt_d[0]};
			end
			// saturate so an overlong frame can never wrap to a match
			if (cnt_q != 5'h1F) begin
				cnt_d = cnt_q + 5'h01;
			end
		end
	end

	always_ff @(posedge link_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync1_q  <= 3'h0;
			sync2_q  <= 3'h0;
			sync3_q  <= 3'h0;
			filt_q   <= 3'h0;
			active_q <= 1'b0;
			cnt_q    <= 5'h00;
			bits_q   <= 27'h0000000;
			tgl_q    <= 1'b0;
			core_q   <= 1'b0;
			nb_q     <= 1'b0;
			code_q   <= 8'h00;
			psi0_q   <= 1'b1;
			psi1_q   <= 1'b1;
		end else begin
			sync1_q  <= {power_ok_input_i, vid_link_clock_i,
				vid_link_data_i};
			sync2_q  <= sync1_q;
			sync3_q  <= sync2_q;
			filt_q   <= filt_d;
			active_q <= active_d;
			cnt_q    <= cnt_d;
			bits_q   <= bits_d;
			tgl_q    <= tgl_d;
			core_q   <= core_d;
			nb_q     <= nb_d;
			code_q   <= code_d;
			psi0_q   <= psi0_d;
			psi1_q   <= psi1_d;
		end
	end

	// receive only: the ack slots stay released
	assign vid_link_data_o      = 1'b1;
	assign vid_link_data_oe_n_o = 1'b1;
	assign frame_tgl_o          = tgl_q;
	assign frame_sel_core_o     = core_q;
	assign frame_sel_nb_o       = nb_q;
	assign frame_code_o         = code_q;
	assign frame_psi0_n_o       = psi0_q;
	assign frame_psi1_n_o       = psi1_q;

endmodule : svr_link_rx

// ==== svr_pkg.sv ====
package svr_pkg;

	// reference clock and code step
	localparam int unsigned CLK_NS  = 40;
	localparam int unsigned STEP_UV = 6250;

	// strap selectable slew rates, in uV per us
	localparam int unsigned RATE_20_UV_US = 20000;
	localparam int unsigned RATE_15_UV_US = 15000;
	localparam int unsigned RATE_12_UV_US = 12500;
	localparam int unsigned RATE_10_UV_US = 10000;

	// slow tracking rate used while the output decays on its own
	localparam int unsigned DECAY_RATE_UV_US = 2500;

	localparam int unsigned CNT_W = 8;

	// least time per code step, rounded up to whole cycles
	function automatic int unsigned cycles_for(int unsigned rate_uv_us);
		return (STEP_UV * 1000 + rate_uv_us * CLK_NS - 1)
			/ (rate_uv_us * CLK_NS);
	endfunction : cycles_for

	localparam logic [CNT_W-1:0] STEP_CYC_20 =
		CNT_W'(cycles_for(RATE_20_UV_US));
	localparam logic [CNT_W-1:0] STEP_CYC_15 =
		CNT_W'(cycles_for(RATE_15_UV_US));
	localparam logic [CNT_W-1:0] STEP_CYC_12 =
		CNT_W'(cycles_for(RATE_12_UV_US));
	localparam logic [CNT_W-1:0] STEP_CYC_10 =
		CNT_W'(cycles_for(RATE_10_UV_US));
	localparam logic [CNT_W-1:0] DECAY_CYC =
		CNT_W'(cycles_for(DECAY_RATE_UV_US));

	// strap code to step period
	function automatic logic [CNT_W-1:0] step_for_strap(logic [1:0] s);
		logic [CNT_W-1:0] r;
		unique case (s)
			2'h0: r = STEP_CYC_20;
			2'h1: r = STEP_CYC_15;
			2'h2: r = STEP_CYC_12;
			2'h3: r = STEP_CYC_10;
		endcase
		return r;
	endfunction : step_for_strap

	// reference code held from reset until the first command
	localparam logic [7:0] RESET_CODE = 8'h58;
	localparam logic [1:0] RESET_STRAP = 2'h3;
	// edges before the strap synchroniser holds the pin level
	localparam logic [1:0] STRAP_WAIT  = 2'h3;

	// frame layout: 27 bit slots, msb first, acks included
	localparam logic [4:0] FRAME_BITS = 5'h1B;
	// data slots plus the clock rise that opens the stop
	localparam logic [4:0] FRAME_RISES = 5'h1C;
	localparam logic [4:0] ADDR_TAG   = 5'h18;
	localparam int unsigned TAG_HI    = 26;
	localparam int unsigned TAG_LO    = 22;
	localparam int unsigned SEL_CORE  = 21;
	localparam int unsigned SEL_NB    = 20;
	localparam int unsigned ZERO_BIT  = 19;
	localparam int unsigned PSI0_BIT  = 17;
	localparam int unsigned CODE_HI   = 16;
	localparam int unsigned CODE_MID  = 10;
	localparam int unsigned CODE_LSB  = 8;
	localparam int unsigned PSI1_BIT  = 7;

	localparam int unsigned DOMAINS = 2;

endpackage : svr_pkg

// ==== svr_ramp.sv ====
`timescale 1ns/10ps
module svr_ramp
	import svr_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	input  wire logic       link_clk_i,
	input  wire logic       power_ok_input_i,
	input  wire logic [1:0] slew_strap_pin_i,
	input  wire logic       vid_link_clock_i,
	input  wire logic       vid_link_data_i,
	output logic            vid_link_data_o,
	output logic            vid_link_data_oe_n_o,
	output logic [7:0]      core_voltage_id_o,
	output logic [7:0]      nb_voltage_id_o,
	output logic [7:0]      core_target_o,
	output logic [7:0]      nb_target_o,
	output logic            core_ramping_o,
	output logic            nb_ramping_o,
	output logic            core_decay_o,
	output logic            nb_decay_o,
	output logic            core_low_power_o,
	output logic            nb_low_power_o,
	output logic            core_deep_power_o,
	output logic            nb_deep_power_o
);
	import svr_pkg::*;

	logic            tgl_w;
	logic            sel_core_w;
	logic            sel_nb_w;
	logic [7:0]      code_w;
	logic            psi0_n_w;
	logic            psi1_n_w;

	svr_link_rx u_rx (
		.link_clk_i           (link_clk_i),
		.nrst_i               (nrst_i),
		.power_ok_input_i     (power_ok_input_i),
		.vid_link_clock_i     (vid_link_clock_i),
		.vid_link_data_i      (vid_link_data_i),
		.vid_link_data_o      (vid_link_data_o),
		.vid_link_data_oe_n_o (vid_link_data_oe_n_o),
		.frame_tgl_o          (tgl_w),
		.frame_sel_core_o     (sel_core_w),
		.frame_sel_nb_o       (sel_nb_w),
		.frame_code_o         (code_w),
		.frame_psi0_n_o       (psi0_n_w),
		.frame_psi1_n_o       (psi1_n_w)
	);

	// bit 3 frame toggle, bit 2 power ok, bits 1:0 strap
	logic [3:0]      sync1_q;
	logic [3:0]      sync2_q;
	logic [3:0]      sync3_q;
	logic            pok_q;
	logic            pok_d;
	logic            strap_done_q;
	logic            strap_done_d;
	logic [1:0]      strap_age_q;
	logic [1:0]      strap_age_d;
	logic [CNT_W-1:0] step_cyc_q;
	logic [CNT_W-1:0] step_cyc_d;
	logic            new_frame_w;
	logic [DOMAINS-1:0] sel_w;

	// frame fields stay put long after the toggle, so sampling
	// them on the detected edge is safe without their own sync
	always_comb begin
		new_frame_w  = (sync2_q[3] != sync3_q[3]) && pok_q;
		sel_w        = {sel_nb_w, sel_core_w};
		pok_d        = pok_q;
		if (sync2_q[2] == sync3_q[2]) begin
			pok_d = sync3_q[2];
		end
		strap_done_d = strap_done_q;
		strap_age_d  = strap_age_q;
		step_cyc_d   = step_cyc_q;
		// stage three holds reset zeros until the pin has passed through
		if (strap_age_q != STRAP_WAIT) begin
			strap_age_d = strap_age_q + 2'h1;
		end
		// rate locks once after reset and never moves in operation
		if (!strap_done_q && strap_age_q == STRAP_WAIT
			&& sync2_q[1:0] == sync3_q[1:0]) begin
			strap_done_d = 1'b1;
			step_cyc_d   = step_for_strap(sync3_q[1:0]);
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync1_q      <= 4'h0;
			sync2_q      <= 4'h0;
			sync3_q      <= 4'h0;
			pok_q        <= 1'b0;
			strap_done_q <= 1'b0;
			strap_age_q  <= 2'h0;
			step_cyc_q   <= step_for_strap(RESET_STRAP);
		end else begin
			sync1_q      <= {tgl_w, power_ok_input_i, slew_strap_pin_i};
			sync2_q      <= sync1_q;
			sync3_q      <= sync2_q;
			pok_q        <= pok_d;
			strap_done_q <= strap_done_d;
			strap_age_q  <= strap_age_d;
			step_cyc_q   <= step_cyc_d;
		end
	end

	// index 0 core, index 1 northbridge; a smaller code is a
	// higher level, one code per 6.25 mV
	logic [7:0]       ref_q  [DOMAINS];
	logic [7:0]       ref_d  [DOMAINS];
	logic [7:0]       tgt_q  [DOMAINS];
	logic [7:0]       tgt_d  [DOMAINS];
	logic [CNT_W-1:0] cnt_q  [DOMAINS];
	logic [CNT_W-1:0] cnt_d  [DOMAINS];
	logic             dec_q  [DOMAINS];
	logic             dec_d  [DOMAINS];
	logic             psi0_q [DOMAINS];
	logic             psi0_d [DOMAINS];
	logic             psi1_q [DOMAINS];
	logic             psi1_d [DOMAINS];

	// descent style comes from the command that set the target
	function automatic logic decay_style(logic [7:0] code,
		logic [7:0] now, logic p0_n, logic p1_n);
		return (code > now) && (!p0_n || !p1_n);
	endfunction : decay_style

	always_comb begin
		for (int i = 0; i < DOMAINS; i++) begin
			ref_d[i]  = ref_q[i];
			tgt_d[i]  = tgt_q[i];
			cnt_d[i]  = cnt_q[i];
			dec_d[i]  = dec_q[i];
			psi0_d[i] = psi0_q[i];
			psi1_d[i] = psi1_q[i];
			if (cnt_q[i] != '0) begin
				cnt_d[i] = cnt_q[i] - 1'b1;
			end else if (ref_q[i] != tgt_q[i]) begin
				// linear code scale across the whole range
				if (ref_q[i] > tgt_q[i]) begin
					ref_d[i] = ref_q[i] - 8'h01;
				end else begin
					ref_d[i] = ref_q[i] + 8'h01;
				end
				cnt_d[i] = dec_q[i] ? DECAY_CYC : step_cyc_q;
			end
			if (new_frame_w && sel_w[i]) begin
				tgt_d[i]  = code_w;
				psi0_d[i] = ~psi0_n_w;
				psi1_d[i] = ~psi1_n_w;
				// descent style comes from this same command
				dec_d[i]  = decay_style(code_w, ref_q[i],
					psi0_n_w, psi1_n_w);
				// a fresh period keeps the step spacing honest
				cnt_d[i]  = decay_style(code_w, ref_q[i],
					psi0_n_w, psi1_n_w)
					? DECAY_CYC : step_cyc_q;
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < DOMAINS; i++) begin
				ref_q[i]  <= RESET_CODE;
				tgt_q[i]  <= RESET_CODE;
				cnt_q[i]  <= '0;
				dec_q[i]  <= 1'b0;
				psi0_q[i] <= 1'b0;
				psi1_q[i] <= 1'b0;
			end
		end else begin
			for (int i = 0; i < DOMAINS; i++) begin
				ref_q[i]  <= ref_d[i];
				tgt_q[i]  <= tgt_d[i];
				cnt_q[i]  <= cnt_d[i];
				dec_q[i]  <= dec_d[i];
				psi0_q[i] <= psi0_d[i];
				psi1_q[i] <= psi1_d[i];
			end
		end
	end

	assign core_voltage_id_o = ref_q[0];
	assign nb_voltage_id_o   = ref_q[1];
	assign core_target_o     = tgt_q[0];
	assign nb_target_o       = tgt_q[1];
	assign core_ramping_o    = ref_q[0] != tgt_q[0];
	assign nb_ramping_o      = ref_q[1] != tgt_q[1];
	assign core_decay_o      = dec_q[0];
	assign nb_decay_o        = dec_q[1];
	// second bit alone never drops phases
	assign core_low_power_o  = psi0_q[0];
	assign nb_low_power_o    = psi0_q[1];
	assign core_deep_power_o = psi0_q[0] & psi1_q[0];
	assign nb_deep_power_o   = psi0_q[1] & psi1_q[1];

endmodule : svr_ramp

// ==== svr_ramp_asserts.sv ====
`timescale 1ns/10ps
module svr_ramp_asserts (
	input wire logic       clk_i,
	input wire logic       nrst_i,
	input wire logic       power_ok_input_i,
	input wire logic       vid_link_data_oe_n_o,
	input wire logic [7:0] core_voltage_id_o,
	input wire logic [7:0] core_target_o,
	input wire logic       core_ramping_o,
	input wire logic       core_decay_o,
	input wire logic       core_low_power_o,
	input wire logic       core_deep_power_o
);
	default clocking dc @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	property p_no_drive;
		vid_link_data_oe_n_o;
	endproperty
	a_no_drive: assert property (p_no_drive)
		else $error("data line driven");
	property p_step;
		$changed(core_voltage_id_o) |-> core_voltage_id_o ==
			($past(core_target_o) > $past(core_voltage_id_o) ?
			$past(core_voltage_id_o) + 8'h01 : $past(core_voltage_id_o) - 8'h01);
	endproperty
	a_step: assert property (p_step)
		else $error("step not one code toward target");
	property p_gap;
		$changed(core_voltage_id_o) |=> $stable(core_voltage_id_o)[*8];
	endproperty
	a_gap: assert property (p_gap)
		else $error("steps too close");
	property p_hold;
		!core_ramping_o && $stable(core_target_o) |=> $stable(core_voltage_id_o);
	endproperty
	a_hold: assert property (p_hold)
		else $error("reference moved past target");
	// with a steady target, a ramp only ends by the reference landing on it
	property p_flag;
		$fell(core_ramping_o) && $stable(core_target_o)
			|-> $changed(core_voltage_id_o);
	endproperty
	a_flag: assert property (p_flag)
		else $error("ramp ended without a final step");
	// sync stages let a frame already in flight land first
	property p_quiet;
		!power_ok_input_i[*8] |-> $stable(core_target_o);
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("target moved without power ok");
	property p_decay_dir;
		core_decay_o && core_ramping_o |-> core_target_o > core_voltage_id_o;
	endproperty
	a_decay_dir: assert property (p_decay_dir)
		else $error("decay on a rising voltage");
	property p_rank;
		core_deep_power_o |-> core_low_power_o;
	endproperty
	a_rank: assert property (p_rank)
		else $error("deep state without first bit");
endmodule : svr_ramp_asserts

bind svr_ramp svr_ramp_asserts svr_ramp_asserts_i (.*);

// ==== svr_tb.sv ====
`timescale 1ns/10ps
module testbench;
	import svr_pkg::*;
	typedef struct {
		logic       c;
		logic       n;
		logic [7:0] v;
		logic [7:0] ec;
		logic [7:0] en;
		logic [1:0] er;
	} svr_row_s;
	logic       clk_i, nrst_i, link_clk_i, power_ok_input_i, sda;
	logic [1:0] slew_strap_pin_i;
	logic       vid_link_clock_i, vid_link_data_i;
	logic       vid_link_data_o, vid_link_data_oe_n_o;
	logic [7:0] core_voltage_id_o, nb_voltage_id_o;
	logic [7:0] core_target_o, nb_target_o;
	logic       core_ramping_o, nb_ramping_o, core_decay_o, nb_decay_o;
	logic       core_low_power_o, nb_low_power_o;
	logic       core_deep_power_o, nb_deep_power_o;
	int         fails, checks_done, cyc, n;
	svr_row_s   rows[4] = '{
		'{1'h1, 1'h0, 8'h50, 8'h50, 8'h58, 2'h1},
		'{1'h0, 1'h1, 8'h5C, 8'h50, 8'h5C, 2'h2},
		'{1'h1, 1'h1, 8'h80, 8'h80, 8'h80, 2'h3},
		'{1'h1, 1'h1, 8'h7C, 8'h7C, 8'h7C, 2'h3}};
	svr_ramp svr_ramp_i (.*);
	svr_host_model svr_host_model_i (.scl_o(vid_link_clock_i), .sda_o(sda));
	// open-drain wire with pull-up
	assign vid_link_data_i = sda & (vid_link_data_oe_n_o | vid_link_data_o);
	initial begin
		clk_i = 1'h0;
		forever #20 clk_i = ~clk_i;
	end
	initial begin
		link_clk_i = 1'h0;
		#1.7;
		forever #3 link_clk_i = ~link_clk_i;
	end
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			summarize();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string m);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic tx(input logic c, input logic n2, input logic [7:0] v,
		input logic p0, input logic p1);
		svr_host_model_i.send(c, n2, v, p0, p1);
		repeat (20) @(posedge clk_i);
		#1;
	endtask : tx
	task automatic settle;
		int k;
		k = 0;
		while ((core_ramping_o !== 1'h0 || nb_ramping_o !== 1'h0) && k < 3000)
		begin
			@(posedge clk_i);
			#1;
			k++;
		end
	endtask : settle
	// counts edges between two reference steps
	task automatic gap(output int g);
		logic [7:0] v;
		g = 0;
		v = core_voltage_id_o;
		while (core_voltage_id_o === v && g < 500) begin
			@(posedge clk_i);
			#1;
			g++;
		end
		v = core_voltage_id_o;
		g = 0;
		while (core_voltage_id_o === v && g < 500) begin
			@(posedge clk_i);
			#1;
			g++;
		end
	endtask : gap
	initial begin
		nrst_i = 1'h0;
		power_ok_input_i = 1'h0;
		slew_strap_pin_i = 2'h0;
		repeat (8) @(posedge clk_i);
		#1 nrst_i = 1'h1;
		repeat (4) @(posedge clk_i);
		#1 power_ok_input_i = 1'h1;
		repeat (4) @(posedge clk_i);
		foreach (rows[i]) begin
			tx(rows[i].c, rows[i].n, rows[i].v, 1'h1, 1'h1);
			chk(core_target_o, rows[i].ec, "core target");
			chk(nb_target_o, rows[i].en, "nb target");
			chk({6'h00, nb_ramping_o, core_ramping_o},
				{6'h00, rows[i].er}, "ramping");
			settle();
			chk(core_voltage_id_o, rows[i].ec, "core ref");
			chk(nb_voltage_id_o, rows[i].en, "nb ref");
		end
		$display("table rows done");
		svr_host_model_i.send(1'h1, 1'h0, 8'h7A, 1'h1, 1'h1);
		gap(n);
		chk(8'(n), 8'(int'(STEP_CYC_20) + 1), "step period");
		settle();
		$display("slew test done");
		svr_host_model_i.send(1'h1, 1'h0, 8'h81, 1'h0, 1'h1);
		gap(n);
		chk(8'(n), 8'(int'(DECAY_CYC) + 1), "decay period");
		chk({7'h00, core_decay_o}, 8'h01, "decay flag");
		chk({7'h00, core_low_power_o}, 8'h01, "low power");
		settle();
		tx(1'h1, 1'h0, 8'h83, 1'h1, 1'h0);
		chk({7'h00, core_low_power_o}, 8'h00, "second bit alone");
		chk({7'h00, core_deep_power_o}, 8'h00, "deep alone");
		settle();
		tx(1'h1, 1'h1, 8'h84, 1'h0, 1'h0);
		chk({7'h00, core_deep_power_o}, 8'h01, "deep state");
		chk({7'h00, nb_deep_power_o}, 8'h01, "nb deep state");
		chk({7'h00, nb_low_power_o}, 8'h01, "nb low power");
		chk({7'h00, nb_decay_o}, 8'h01, "nb decay flag");
		settle();
		$display("power state test done");
		svr_host_model_i.send(1'h1, 1'h0, 8'h60, 1'h1, 1'h1);
		n = 0;
		while (core_voltage_id_o !== 8'h78 && n < 1000) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		tx(1'h1, 1'h0, 8'h7C, 1'h1, 1'h1);
		settle();
		chk(core_voltage_id_o, 8'h7C, "retarget");
		$display("retarget test done");
		#1 power_ok_input_i = 1'h0;
		repeat (10) @(posedge clk_i);
		tx(1'h1, 1'h1, 8'h10, 1'h1, 1'h1);
		chk(core_target_o, 8'h7C, "ignored without power ok");
		chk(nb_target_o, 8'h84, "nb ignored without power ok");
		#1 power_ok_input_i = 1'h1;
		repeat (10) @(posedge clk_i);
		$display("power ok test done");
		#1 nrst_i = 1'h0;
		repeat (3) @(posedge clk_i);
		chk(core_voltage_id_o, RESET_CODE, "reset ref");
		chk(nb_target_o, RESET_CODE, "reset target");
		chk({7'h00, vid_link_data_oe_n_o}, 8'h01, "released");
		chk({7'h00, vid_link_data_o}, 8'h01, "data level");
		#1 nrst_i = 1'h1;
		repeat (4) @(posedge clk_i);
		#1;
		chk(core_voltage_id_o, RESET_CODE, "ref after reset");
		chk({7'h00, core_ramping_o}, 8'h00, "idle after reset");
		$display("reset test done");
		summarize();
	end
endmodule : testbench
